//--- logic/esl_link.sv
// Embedded clock serializer and deserializer with a core side and a link side.
// Assumes the link clock is the serial bit clock and the word clock is about a twentieth of it.
// Operation
// - Transmit and receive halves run independently, each with its own sleep input.
// - Serial output stays high impedance until the transmit PLL has locked.
// - With PLL locked and training request high, send training words.
// - Training word is nine high payload bits then nine low ones.
// - Receive outputs high impedance and unsynced high during reference acquisition.
// - Receiver locks by finding the rising embedded clock edge in the stream.
// - Unsynced falls in the same cycle the first valid word appears.
// - Every frame has a high start bit and a low stop bit.
// - Twenty serial bit times per word: eighteen payload bits, two framing.
// - Parallel word captured on each rising word clock edge while the transmit PLL is locked.
// - After six training request cycles, parallel word capture stops.
// - Recovered word clock follows the output word; word valid while unsynced low.
// - Receive output enable gates output word and recovered clock.
// - Output enable low floats outputs; high restores prior state.
// - Serial input presents high impedance while receive sleep is low.
// - Two successive missing clock edges mean lock lost; hunting restarts.
// - Unlocked receiver drives output word and recovered clock high.
// - Repeating multi-transition pattern refuses lock until the pattern changes.
// - Such a pattern is a low payload bit below 17 with a high one just above it.
// - Receive sleep low stops acquisition and floats outputs.
// - Receive sleep high restarts initialization before data flows.
// - Transmit sleep low stops the PLL and floats the serial output.
// - Transmit sleep high relocks the PLL before data is sent.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Two flop synchronizer
module esl_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,   // Destination clock
  input  wire logic         i_rstn,  // Async reset, active low
  input  wire logic [W-1:0] i_d,     // Foreign level
  output logic      [W-1:0] o_q      // Synchronized level
);
  logic [W-1:0] s1;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1  <= '0;
      o_q <= '0;
    end else begin
      s1  <= i_d;
      o_q <= s1;
    end
  end
endmodule : esl_sync

// ==========================================================
// Top
module esl_link
  import esl_pkg::*;
(
  input  wire logic        I_CORE_CLK,      // Core clock
  input  wire logic        I_RSTN,          // Async reset, active low
  input  wire logic        I_CE,            // Clock enable, freezes state when low
  input  wire logic        I_LINK_CLK,      // Serial bit clock
  input  wire logic        I_TX_WORD_CLK,   // Transmit word clock pin
  input  wire logic        I_TX_SLEEP_N,    // Transmit awake when high
  input  wire logic        I_TX_TRAIN,      // Training request
  input  wire logic [17:0] I_TX_WORD,       // Parallel transmit word
  output logic             O_TX_READY,      // Transmit PLL locked
  output logic             O_SERIAL_TX,     // Serial output level
  output logic             O_SERIAL_TX_OEN, // Serial output enable, low drives
  input  wire logic        I_SERIAL_RX,     // Serial input level
  output logic             O_RX_IN_HIZ,     // Serial input floating
  input  wire logic        I_RX_REF_CLK,    // Receive reference clock pin
  input  wire logic        I_RX_SLEEP_N,    // Receive awake when high
  input  wire logic        I_RX_OUT_EN,     // Receive output enable
  output logic      [17:0] O_RX_WORD,       // Parallel receive word
  output logic             O_RX_WORD_CLK,   // Recovered word clock
  output logic             O_RX_OEN,        // Word and clock enable, low drives
  output logic             O_RX_UNSYNC      // High while not locked
);
  // ==========================================================
  // Core side synchronizers
  logic [5:0]  pins_s;
  logic [17:0] din_s;
  logic        wclk_d;
  logic        ref_d;
  logic        pkt_tgl_s;
  logic        pkt_tgl_d;
  logic        wclk_s, ref_s, tx_awake, train_s, rx_awake, out_en_s;

  esl_sync #(.W(6)) u_pins_sync (
    .i_clk  (I_CORE_CLK),
    .i_rstn (I_RSTN),
    .i_d    ({I_TX_WORD_CLK, I_RX_REF_CLK, I_TX_SLEEP_N, I_TX_TRAIN, I_RX_SLEEP_N, I_RX_OUT_EN}),
    .o_q    (pins_s)
  );
  esl_sync #(.W(18)) u_din_sync (
    .i_clk  (I_CORE_CLK),
    .i_rstn (I_RSTN),
    .i_d    (I_TX_WORD),
    .o_q    (din_s)
  );
  assign {wclk_s, ref_s, tx_awake, train_s, rx_awake, out_en_s} = pins_s;

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      wclk_d    <= 1'b0;
      ref_d     <= 1'b0;
      pkt_tgl_d <= 1'b0;
    end else if (I_CE) begin
      wclk_d    <= wclk_s;
      ref_d     <= ref_s;
      pkt_tgl_d <= pkt_tgl_s;
    end
  end

  logic wclk_rise, ref_rise, pkt_new;
  assign wclk_rise = wclk_s & ~wclk_d;
  assign ref_rise  = ref_s & ~ref_d;
  assign pkt_new   = pkt_tgl_s ^ pkt_tgl_d;

  // ==========================================================
  // Transmit PLL and word capture
  logic [4:0]  tx_pll_cnt;
  logic [2:0]  train_cnt;
  logic [2:0]  next_train_cnt;
  logic [17:0] tx_din_hold;
  logic [17:0] tx_word;
  logic        tx_tgl;
  logic        tx_locked;

  assign tx_locked = (tx_pll_cnt == TX_PLL_EDGES);

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      tx_pll_cnt <= '0;
      O_TX_READY <= 1'b0;
    end else if (I_CE) begin
      if (!tx_awake) begin
        tx_pll_cnt <= '0;
      end else if (wclk_rise && !tx_locked) begin
        tx_pll_cnt <= tx_pll_cnt + 5'h01;
      end
      O_TX_READY <= tx_awake && tx_locked;
    end
  end

  always_comb begin
    next_train_cnt = 3'h0;
    if (train_s) begin
      next_train_cnt = (train_cnt == TRAIN_HOLD) ? TRAIN_HOLD : train_cnt + 3'h1;
    end
  end

  // Capture only when locked, so a relocking PLL never ships a torn word
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      train_cnt   <= '0;
      tx_din_hold <= '0;
      tx_word     <= '0;
      tx_tgl      <= 1'b0;
    end else if (I_CE && wclk_rise && tx_awake && tx_locked) begin
      train_cnt <= next_train_cnt;
      if (next_train_cnt != TRAIN_HOLD) begin
        tx_din_hold <= din_s;
      end
      if (train_s) begin
        tx_word <= TRAIN_WORD;
      end else begin
        tx_word <= (next_train_cnt != TRAIN_HOLD) ? din_s : tx_din_hold;
      end
      tx_tgl <= ~tx_tgl;
    end
  end

  // ==========================================================
  // Receive reference acquisition and output side
  logic [4:0]     ref_cnt;
  logic           ref_ok;
  logic [2:0]     rclk_cnt;
  logic           rx_run;
  logic           rx_run_q;
  esl_rx_pkt_type rx_pkt;

  assign ref_ok = (ref_cnt == REF_PLL_EDGES);
  assign rx_run = rx_awake && ref_ok;

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ref_cnt <= '0;
    end else if (I_CE) begin
      if (!rx_awake) begin
        ref_cnt <= '0;
      end else if (ref_rise && !ref_ok) begin
        ref_cnt <= ref_cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_RX_OEN    <= 1'b1;
      O_RX_IN_HIZ <= 1'b1;
      rx_run_q    <= 1'b0;
    end else if (I_CE) begin
      O_RX_OEN    <= !(rx_run && out_en_s);
      O_RX_IN_HIZ <= !rx_awake;
      // Registered so a comparator glitch never reaches the link synchronizer
      rx_run_q    <= rx_run;
    end
  end

  // Word and lock state travel together so unsync and data change in one cycle
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_RX_WORD     <= FAILSAFE_WORD;
      O_RX_WORD_CLK <= 1'b1;
      O_RX_UNSYNC   <= 1'b1;
      rclk_cnt      <= '0;
    end else if (I_CE) begin
      if (!rx_run) begin
        O_RX_WORD     <= FAILSAFE_WORD;
        O_RX_WORD_CLK <= 1'b1;
        O_RX_UNSYNC   <= 1'b1;
        rclk_cnt      <= '0;
      end else if (pkt_new && rx_pkt.locked) begin
        O_RX_WORD     <= rx_pkt.word;
        O_RX_UNSYNC   <= 1'b0;
        O_RX_WORD_CLK <= 1'b0;
        rclk_cnt      <= RCLK_LOW_CYC;
      end else if (pkt_new) begin
        O_RX_WORD     <= FAILSAFE_WORD;
        O_RX_UNSYNC   <= 1'b1;
        O_RX_WORD_CLK <= 1'b1;
        rclk_cnt      <= '0;
      end else if (rclk_cnt != 3'h0) begin
        rclk_cnt <= rclk_cnt - 3'h1;
        if (rclk_cnt == 3'h1) begin
          O_RX_WORD_CLK <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Link domain reset and synchronizers
  logic [1:0] lrst_s;
  logic       lrst_n;
  logic [4:0] link_s;
  logic       ce_l, tx_run_l, rx_run_l, tx_tgl_l, srx;
  logic       tx_tgl_ld;

  always_ff @(posedge I_LINK_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      lrst_s <= 2'h0;
    end else begin
      lrst_s <= {lrst_s[0], 1'b1};
    end
  end
  assign lrst_n = lrst_s[1];

  esl_sync #(.W(5)) u_link_sync (
    .i_clk  (I_LINK_CLK),
    .i_rstn (lrst_n),
    .i_d    ({I_CE, O_TX_READY, rx_run_q, tx_tgl, I_SERIAL_RX}),
    .o_q    (link_s)
  );
  assign {ce_l, tx_run_l, rx_run_l, tx_tgl_l, srx} = link_s;

  // ==========================================================
  // Serializer
  logic [4:0]  bit_cnt;
  logic [17:0] tx_shadow;
  logic [17:0] tx_frame;

  // Word register is stable for many bit times after its toggle flips
  always_ff @(posedge I_LINK_CLK or negedge lrst_n) begin
    if (!lrst_n) begin
      tx_tgl_ld <= 1'b0;
      tx_shadow <= '0;
    end else if (ce_l) begin
      tx_tgl_ld <= tx_tgl_l;
      if (tx_tgl_l != tx_tgl_ld) begin
        tx_shadow <= tx_word;
      end
    end
  end

  always_ff @(posedge I_LINK_CLK or negedge lrst_n) begin
    if (!lrst_n) begin
      bit_cnt         <= '0;
      tx_frame        <= '0;
      O_SERIAL_TX     <= 1'b0;
      O_SERIAL_TX_OEN <= 1'b1;
    end else if (ce_l) begin
      if (!tx_run_l) begin
        bit_cnt         <= '0;
        O_SERIAL_TX     <= 1'b0;
        O_SERIAL_TX_OEN <= 1'b1;
      end else begin
        O_SERIAL_TX_OEN <= 1'b0;
        bit_cnt         <= (bit_cnt == FRAME_LAST) ? 5'h00 : bit_cnt + 5'h01;
        if (bit_cnt == 5'h00) begin
          tx_frame    <= tx_shadow;
          O_SERIAL_TX <= 1'b1;
        end else if (bit_cnt == FRAME_LAST) begin
          O_SERIAL_TX <= 1'b0;
        end else begin
          O_SERIAL_TX <= tx_frame[bit_cnt - 5'h01];
        end
      end
    end
  end

  // ==========================================================
  // Deserializer and lock tracking
  esl_rx_state_type rx_state;
  logic [20:0]      win;
  logic [4:0]       ph;
  logic [2:0]       good_cnt;
  logic [1:0]       miss_cnt;
  logic [17:0]      last_pay;
  logic             pkt_tgl;
  logic             bound, clk_ok, rmt_hit, repeating_multi_edge_pattern;
  logic [17:0]      pay;

  assign bound   = (ph == FRAME_LAST);
  assign pay     = win[19:2];
  assign clk_ok  = !win[0] && win[1] && !win[20];
  // A rising edge inside the payload gives a second clock candidate
  assign rmt_hit = |(~pay[16:0] & pay[17:1]);
  assign repeating_multi_edge_pattern     = rmt_hit && (pay == last_pay);

  always_ff @(posedge I_LINK_CLK or negedge lrst_n) begin
    if (!lrst_n) begin
      win <= '0;
    end else if (ce_l) begin
      win <= {srx, win[20:1]};
    end
  end

  // Random data may slip for a long time; training words lock in a few frames
  always_ff @(posedge I_LINK_CLK or negedge lrst_n) begin
    if (!lrst_n) begin
      rx_state <= ESL_HUNT;
      ph       <= '0;
      good_cnt <= '0;
      miss_cnt <= '0;
      last_pay <= '0;
      rx_pkt   <= '0;
      pkt_tgl  <= 1'b0;
    end else if (ce_l) begin
      if (!rx_run_l) begin
        rx_state <= ESL_HUNT;
        ph       <= '0;
        good_cnt <= '0;
        miss_cnt <= '0;
      end else if (!bound) begin
        ph <= ph + 5'h01;
      end else begin
        last_pay <= pay;
        ph       <= 5'h00;
        case (rx_state)
          ESL_HUNT: begin
            if (!clk_ok) begin
              ph       <= FRAME_LAST;
              good_cnt <= '0;
            end else if (repeating_multi_edge_pattern) begin
              good_cnt <= '0;
            end else if (good_cnt + 3'h1 == LOCK_FRAMES) begin
              rx_state <= ESL_LOCKED;
              good_cnt <= '0;
              miss_cnt <= '0;
              rx_pkt   <= '{locked: 1'b1, word: pay};
              pkt_tgl  <= ~pkt_tgl;
            end else begin
              good_cnt <= good_cnt + 3'h1;
            end
          end
          ESL_LOCKED: begin
            pkt_tgl <= ~pkt_tgl;
            if (clk_ok) begin
              miss_cnt <= '0;
              rx_pkt   <= '{locked: 1'b1, word: pay};
            end else if (miss_cnt + 2'h1 == MISS_LIMIT) begin
              rx_state <= ESL_HUNT;
              miss_cnt <= '0;
              rx_pkt   <= '{locked: 1'b0, word: FAILSAFE_WORD};
            end else begin
              miss_cnt <= miss_cnt + 2'h1;
              rx_pkt   <= '{locked: 1'b1, word: pay};
            end
          end
          default: begin
            rx_state <= ESL_HUNT;
          end
        endcase
      end
    end
  end

  esl_sync #(.W(1)) u_pkt_sync (
    .i_clk  (I_CORE_CLK),
    .i_rstn (I_RSTN),
    .i_d    (pkt_tgl),
    .o_q    (pkt_tgl_s)
  );

  // ==========================================================
  // Checks
  sequence link_step_s;
    ce_l && tx_run_l;
  endsequence

  sequence rx_bound_s;
    ce_l && rx_run_l && bound;
  endsequence

  tx_hiz_idle_a: assert property (@(posedge I_LINK_CLK) disable iff (!lrst_n)
    (ce_l && !tx_run_l) |=> O_SERIAL_TX_OEN)
    else $error("Serial output driven while not ready");

  start_bit_a: assert property (@(posedge I_LINK_CLK) disable iff (!lrst_n)
    (link_step_s and bit_cnt == 5'h00) |=> (O_SERIAL_TX && !O_SERIAL_TX_OEN))
    else $error("Start bit not high");

  stop_bit_a: assert property (@(posedge I_LINK_CLK) disable iff (!lrst_n)
    (link_step_s and bit_cnt == FRAME_LAST) |=> (!O_SERIAL_TX && bit_cnt == 5'h00))
    else $error("Stop bit not low or frame not 20 bits");

  payload_order_a: assert property (@(posedge I_LINK_CLK) disable iff (!lrst_n)
    (link_step_s and bit_cnt == 5'h01) |=> (O_SERIAL_TX == $past(tx_frame[0])))
    else $error("First payload bit out of order");

  train_word_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
    (I_CE && wclk_rise && tx_awake && tx_locked && train_s) |=> (tx_word == TRAIN_WORD))
    else $error("Training word not sent");

  train_freeze_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
    (I_CE && wclk_rise && tx_locked && train_s && train_cnt == TRAIN_HOLD) |=> $stable(tx_din_hold))
    else $error("Capture continued during long training");

  rx_hiz_init_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
    (I_CE && !rx_run) |=> (O_RX_OEN && O_RX_UNSYNC))
    else $error("Receive outputs active before acquisition");

  unsync_word_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
    (I_CE && rx_run && pkt_new && rx_pkt.locked) |=> (!O_RX_UNSYNC && O_RX_WORD == $past(rx_pkt.word)))
    else $error("Unsync and word not updated together");

  lock_loss_a: assert property (@(posedge I_LINK_CLK) disable iff (!lrst_n)
    (rx_bound_s and rx_state == ESL_LOCKED && !clk_ok && miss_cnt == 2'h1) |=> (rx_state == ESL_HUNT))
    else $error("Two misses did not drop lock");

  rmt_refuse_a: assert property (@(posedge I_LINK_CLK) disable iff (!lrst_n)
    (rx_bound_s and rx_state == ESL_HUNT && clk_ok && repeating_multi_edge_pattern) |=> (rx_state == ESL_HUNT && good_cnt == 3'h0))
    else $error("Locked on repeating multi-edge pattern");
endmodule : esl_link

`default_nettype wire

//--- logic/esl_pkg.sv
// Constants and carrier types for the embedded clock serial link.
// Assumes one core clock and one serial bit clock, one bit per link clock edge.
package esl_pkg;
  // ==========================================================
  // Framing
  localparam int          WORD_W        = 18;
  localparam logic [4:0]  FRAME_LAST    = 5'h13;   // 20 bit times per frame
  localparam logic [4:0]  PAYLOAD_LAST  = 5'h12;   // Start bit plus 18 payload bits
  localparam logic [17:0] TRAIN_WORD    = 18'h0_01FF;
  localparam logic [17:0] FAILSAFE_WORD = 18'h3_FFFF;
  // ==========================================================
  // Counts
  localparam logic [2:0]  TRAIN_HOLD    = 3'h6;
  localparam logic [4:0]  TX_PLL_EDGES  = 5'h10;
  localparam logic [4:0]  REF_PLL_EDGES = 5'h10;
  localparam logic [2:0]  LOCK_FRAMES   = 3'h4;
  localparam logic [1:0]  MISS_LIMIT    = 2'h2;
  localparam logic [2:0]  RCLK_LOW_CYC  = 3'h3;
  // ==========================================================
  // Types
  typedef enum logic {
    ESL_HUNT,
    ESL_LOCKED
  } esl_rx_state_type;

  typedef struct packed {
    logic        locked;
    logic [17:0] word;
  } esl_rx_pkt_type;
endpackage : esl_pkg

//--- testbench/esl_peer.sv
// Far end of the serial link for the bench.
// Assumes one serial bit per rising link clock edge and no line delay beyond one bit.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Peer
module esl_peer (
  input  wire logic i_link_clk, // Link clock
  input  wire logic i_cut,      // Cable pulled, line low
  input  wire logic i_tx,       // Serial level from the block
  input  wire logic i_tx_oen,   // Block drive enable, low drives
  output logic      o_rx        // Serial level to the block
);
  initial o_rx = 1'b0;
  // Loops the block's stream back; a released line toggles so no stale level is seen
  always @(posedge i_link_clk) begin
    if (i_cut) begin
      o_rx <= 1'b0;
    end else if (i_tx_oen) begin
      o_rx <= ~o_rx;
    end else begin
      o_rx <= i_tx;
    end
  end
endmodule : esl_peer

`default_nettype wire

//--- testbench/esl_link_tb.sv
// Self-checking bench for the embedded clock serial link, looped back through the peer.
// Assumes word and reference clocks near a twentieth of the link clock.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Bench
module esl_link_tb
  import esl_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        wclk     = 1'b0;
  logic        ref_clk  = 1'b0;
  logic        wclk_run = 1'b1;
  logic        rstn     = 1'b0;
  logic        tx_sleep_n = 1'b1;
  logic        tx_train = 1'b1;
  logic        rx_sleep_n = 1'b1;
  logic        rx_out_en = 1'b1;
  logic        cut      = 1'b0;
  logic        fb       = 1'b0;
  logic        ce       = 1'b1;
  wire logic   train_pin;
  logic [17:0] tx_word  = 18'h2_5A3C;
  wire logic        tx_ready, ser_tx, ser_tx_oen, ser_rx, rx_in_hiz, rx_wclk, rx_oen, rx_unsync;
  wire logic [17:0] rx_word;
  int          err_count  = 0;
  int          num_checks = 0;

  // Pin clocks sit half a nanosecond off the core edges, so sampling them never races
  always #2 core_clk = ~core_clk;
  always #7.5 link_clk = ~link_clk;
  always #151 ref_clk <= #0.5 ~ref_clk;
  always #150 if (wclk_run) wclk <= #0.5 ~wclk;
  // Training request follows the receiver's lock state once feedback is on
  assign train_pin = fb ? rx_unsync : tx_train;

  esl_link DUT (
    .I_CORE_CLK(core_clk), .I_RSTN(rstn), .I_CE(ce), .I_LINK_CLK(link_clk),
    .I_TX_WORD_CLK(wclk), .I_TX_SLEEP_N(tx_sleep_n), .I_TX_TRAIN(train_pin), .I_TX_WORD(tx_word),
    .O_TX_READY(tx_ready), .O_SERIAL_TX(ser_tx), .O_SERIAL_TX_OEN(ser_tx_oen),
    .I_SERIAL_RX(ser_rx), .O_RX_IN_HIZ(rx_in_hiz), .I_RX_REF_CLK(ref_clk),
    .I_RX_SLEEP_N(rx_sleep_n), .I_RX_OUT_EN(rx_out_en), .O_RX_WORD(rx_word),
    .O_RX_WORD_CLK(rx_wclk), .O_RX_OEN(rx_oen), .O_RX_UNSYNC(rx_unsync)
  );
  esl_peer peer (.i_link_clk(link_clk), .i_cut(cut), .i_tx(ser_tx), .i_tx_oen(ser_tx_oen), .o_rx(ser_rx));

  // ==========================================================
  // Helpers
  task automatic chk_w(input logic [17:0] got, input logic [17:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_w

  task automatic chk_b(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_b

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  // Select 0 watches unsync, 1 watches transmit ready
  task automatic wait_on(input int sel, input logic v, input int n);
    int i;
    i = 0;
    while (((sel == 0) ? rx_unsync : tx_ready) !== v && i < n) begin
      cyc(1);
      i++;
    end
    chk_b((sel == 0) ? rx_unsync : tx_ready, v);
  endtask : wait_on

  // ==========================================================
  // Scenarios
  task automatic s_init();
    wait_on(1, 1'b1, 3000);
    cyc(20);
    chk_b(ser_tx_oen, 1'b0);
    wait_on(0, 1'b0, 6000);
    chk_w(rx_word, TRAIN_WORD);
    chk_b(rx_wclk, 1'b0);
    chk_b(rx_oen, 1'b0);
  endtask : s_init

  task automatic s_hold();
    @(posedge core_clk) tx_train <= 1'b0;
    cyc(600);
    chk_b(rx_unsync, 1'b0);
    chk_w(rx_word, 18'h2_5A3C);
    @(posedge core_clk) tx_train <= 1'b1;
    cyc(600);
    @(posedge core_clk) tx_word <= 18'h1_0F0F;
    cyc(300);
    wclk_run = 1'b0;
    @(posedge core_clk) tx_train <= 1'b0;
    cyc(600);
    // No word clock edge since training ended, so nothing new is taken
    chk_w(rx_word, TRAIN_WORD);
    wclk_run = 1'b1;
    cyc(600);
    chk_w(rx_word, 18'h1_0F0F);
  endtask : s_hold

  task automatic s_oen();
    @(posedge core_clk) rx_out_en <= 1'b0;
    cyc(10);
    chk_b(rx_oen, 1'b1);
    @(posedge core_clk) rx_out_en <= 1'b1;
    cyc(10);
    chk_b(rx_oen, 1'b0);
    chk_b(rx_unsync, 1'b0);
    chk_w(rx_word, 18'h1_0F0F);
    // Clock enable low freezes the enable flop even though its input moves
    @(posedge core_clk);
    ce <= 1'b0;
    rx_out_en <= 1'b0;
    cyc(10);
    chk_b(rx_oen, 1'b0);
    @(posedge core_clk) ce <= 1'b1;
    cyc(10);
    chk_b(rx_oen, 1'b1);
    @(posedge core_clk) rx_out_en <= 1'b1;
    cyc(10);
  endtask : s_oen

  task automatic s_loss();
    @(posedge core_clk) cut <= 1'b1;
    wait_on(0, 1'b1, 2000);
    chk_w(rx_word, FAILSAFE_WORD);
    chk_b(rx_wclk, 1'b1);
    @(posedge core_clk) tx_word <= 18'h0_0002;
    cut <= 1'b0;
    cyc(4000);
    chk_b(rx_unsync, 1'b1);
    fb = 1'b1;
    wait_on(0, 1'b0, 6000);
    cyc(600);
    chk_w(rx_word, 18'h0_0002);
  endtask : s_loss

  task automatic s_sleep();
    @(posedge core_clk) rx_sleep_n <= 1'b0;
    cyc(10);
    chk_b(rx_in_hiz, 1'b1);
    chk_b(rx_oen, 1'b1);
    chk_b(rx_unsync, 1'b1);
    chk_b(tx_ready, 1'b1);
    @(posedge core_clk) rx_sleep_n <= 1'b1;
    wait_on(0, 1'b0, 8000);
    chk_b(rx_in_hiz, 1'b0);
    @(posedge core_clk) tx_sleep_n <= 1'b0;
    cyc(20);
    chk_b(tx_ready, 1'b0);
    chk_b(ser_tx_oen, 1'b1);
    @(posedge core_clk) tx_sleep_n <= 1'b1;
    wait_on(1, 1'b1, 3000);
    cyc(20);
    chk_b(ser_tx_oen, 1'b0);
    wait_on(0, 1'b0, 8000);
  endtask : s_sleep

  // ==========================================================
  // Verdict
  task automatic print_verdict();
    if (err_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  initial begin
    cyc(15);
    chk_b(tx_ready, 1'b0);
    chk_b(ser_tx_oen, 1'b1);
    chk_b(rx_oen, 1'b1);
    chk_b(rx_unsync, 1'b1);
    @(posedge core_clk) rstn <= 1'b1;
    s_init();
    s_hold();
    s_oen();
    s_loss();
    s_sleep();
    print_verdict();
  end

  // Run needs about 12k core cycles
  initial begin
    #300000;
    err_count++;
    print_verdict();
  end
endmodule : esl_link_tb

`default_nettype wire
